// *** logic/fsss_pkg.sv ***
// Purpose: constants and types for the flow safe-state supervisor
// Assumes: 250 MHz hclk, 32-bit AHB-Lite register bus
// Notes:   byte offsets; parameter paths packed slot/subslot/index
package fsss_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned FLASH_HZ       = 1;
  localparam int unsigned FLASH_HALF_CYC = CLK_HZ / (2 * FLASH_HZ);
  localparam int unsigned FLASH_CNT_W    = 27;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_ERROR     = 8'h08;
  localparam logic [7:0] OFF_SAFE_ST   = 8'h0c;
  localparam logic [7:0] OFF_SAFE_VAL  = 8'h10;
  localparam logic [7:0] OFF_CAL_INST  = 8'h14;
  localparam logic [7:0] OFF_ALM_MASK  = 8'h18;
  localparam logic [7:0] OFF_WRN_MASK  = 8'h1c;
  localparam logic [7:0] OFF_ALM_STAT  = 8'h20;
  localparam logic [7:0] OFF_IP_ADDR   = 8'h24;
  localparam logic [7:0] OFF_NET_MASK  = 8'h28;
  localparam logic [7:0] OFF_SETPOINT  = 8'h2c;
  localparam logic [7:0] OFF_FLOW      = 8'h30;
  localparam logic [7:0] OFF_NONE      = 8'hff;

  // ****************************************
  // parameter paths {slot, subslot, index}
  // ****************************************
  localparam logic [31:0] PATH_CAL_INST = {8'h02, 8'h01, 16'h0023};
  localparam logic [31:0] PATH_SAFE_ST  = {8'h04, 8'h01, 16'h0015};
  localparam logic [31:0] PATH_SAFE_VAL = {8'h04, 8'h01, 16'h0016};
  localparam logic [31:0] PATH_ERROR    = {8'h07, 8'h01, 16'h0004};
  localparam logic [31:0] PATH_ALM_MASK = {8'h07, 8'h01, 16'h0008};
  localparam logic [31:0] PATH_WRN_MASK = {8'h07, 8'h01, 16'h0009};

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int unsigned CTRL_NO_VALVE  = 0;
  localparam int unsigned ST_SAFE        = 0;
  localparam int unsigned ST_SELFTEST    = 1;
  localparam int unsigned ST_CYCLIC      = 2;
  localparam int unsigned ST_LED_LO      = 4;
  localparam int unsigned ALM_BAD_PAGE   = 0;
  localparam logic [31:0] RST_IP_ADDR    = 32'hc0a80164;
  localparam logic [31:0] RST_NET_MASK   = 32'hffffff00;
  localparam logic [31:0] RST_MASK       = 32'h00000000;
  localparam logic [7:0]  RST_CAL_INST   = 8'h01;
  localparam logic [7:0]  PAGE_MAX       = 8'h06;
  localparam logic [15:0] DRIVE_FULL     = 16'hffff;
  localparam logic [15:0] DRIVE_ZERO     = 16'h0000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SAFE_CLOSED = 2'h0,
    SAFE_OPEN   = 2'h1,
    SAFE_HOLD   = 2'h2,
    SAFE_VALUE  = 2'h3
  } fsss_safe_t;

  typedef enum logic [1:0] {
    LED_DARK,
    LED_TEST,
    LED_FLASH,
    LED_STEADY
  } fsss_led_t;

endpackage

// *** logic/fsss_top.sv ***
// Purpose: safe-mode, indicator and gas page supervisor with AHB-Lite registers
// Assumes: all inputs synchronous to hclk; single word transfers only
// Notes:   reads take one wait state, writes none; record port shares the write path
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
module fsss_top
  import fsss_pkg::*;
#(
  parameter int unsigned HALF_CYC = fsss_pkg::FLASH_HALF_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        ip_configured,
  input  wire logic        name_set,
  input  wire logic        self_test_busy,
  input  wire logic        cyclic_active,
  input  wire logic        meter_only,
  input  wire logic [31:0] error_events,
  input  wire logic [2:0]  cal_module_count,
  input  wire logic        cyc_strobe,
  input  wire logic [7:0]  cyc_page_sel,
  input  wire logic [31:0] flow_setpoint_value,
  input  wire logic [31:0] measured_flow_value,
  input  wire logic [15:0] loop_drive,
  input  wire logic        rec_req,
  input  wire logic        rec_write,
  input  wire logic [7:0]  rec_slot,
  input  wire logic [7:0]  rec_subslot,
  input  wire logic [15:0] rec_index,
  input  wire logic [31:0] rec_wdata,
  output logic             rec_ack,
  output logic             rec_err,
  output logic [31:0]      rec_rdata,
  output logic             safe_mode,
  output logic             loop_halt,
  output logic [15:0]      valve_drive,
  output logic             network_status_indicator_green,
  output logic             network_status_indicator_red
);
  import fsss_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic                   no_valve_q;
  logic [31:0]            err_q;
  fsss_safe_t             safe_st_q;
  logic [15:0]            safe_val_q;
  logic [7:0]             cal_q;
  logic [31:0]            alm_mask_q;
  logic [31:0]            wrn_mask_q;
  logic                   bad_page_q;
  logic [31:0]            ip_q;
  logic [31:0]            nmask_q;
  logic [31:0]            setpt_q;
  logic [31:0]            flow_q;
  logic                   wr_pend_q;
  logic [7:0]             wr_off_q;
  logic                   rd_pend_q;
  logic [7:0]             rd_off_q;
  logic [31:0]            hrdata_q;
  logic                   rec_ack_q;
  logic                   rec_err_q;
  logic [31:0]            rec_rdata_q;
  logic [FLASH_CNT_W-1:0] flash_cnt_q;
  logic                   flash_q;
  fsss_led_t              led_q;
  logic [15:0]            drive_q;
  logic                   safe_q;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] path_off(input logic [31:0] p);
    unique case (p)
      PATH_CAL_INST: path_off = OFF_CAL_INST;
      PATH_SAFE_ST:  path_off = OFF_SAFE_ST;
      PATH_SAFE_VAL: path_off = OFF_SAFE_VAL;
      PATH_ERROR:    path_off = OFF_ERROR;
      PATH_ALM_MASK: path_off = OFF_ALM_MASK;
      PATH_WRN_MASK: path_off = OFF_WRN_MASK;
      default:       path_off = OFF_NONE;
    endcase
  endfunction

  function automatic logic [7:0] bus_off(input logic [31:0] a);
    bus_off = (a[31:8] == 24'h000000 && a[1:0] == 2'b00) ? a[7:0] : OFF_NONE;
  endfunction

  function automatic logic [31:0] rd_mux(input logic [7:0] off);
    unique case (off)
      OFF_CTRL:     rd_mux = {31'h0, no_valve_q};
      OFF_STATUS:   rd_mux = {26'h0, led_q, 1'b0, cyclic_active, self_test_busy, safe_q};
      OFF_ERROR:    rd_mux = err_q;
      OFF_SAFE_ST:  rd_mux = {30'h0, safe_st_q};
      OFF_SAFE_VAL: rd_mux = {16'h0, safe_val_q};
      OFF_CAL_INST: rd_mux = {24'h0, cal_q};
      OFF_ALM_MASK: rd_mux = alm_mask_q;
      OFF_WRN_MASK: rd_mux = wrn_mask_q;
      OFF_ALM_STAT: rd_mux = {31'h0, bad_page_q};
      OFF_IP_ADDR:  rd_mux = ip_q;
      OFF_NET_MASK: rd_mux = nmask_q;
      OFF_SETPOINT: rd_mux = setpt_q;
      OFF_FLOW:     rd_mux = flow_q;
      default:      rd_mux = 32'h00000000;
    endcase
  endfunction

  // a page number is usable only if that calibration module exists
  function automatic logic page_ok(input logic [31:0] v);
    page_ok = (v >= 32'h1) && (v <= {29'h0, cal_module_count});
  endfunction

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic        addr_take;
  logic        rec_take;
  logic [7:0]  rec_off;
  logic        wr_en;
  logic [7:0]  wr_off;
  logic [31:0] wr_data;
  logic        sp_zero;

  assign addr_take = hsel && hready && htrans[1];
  assign hreadyout = !rd_pend_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_off_q  <= 8'h00;
      rd_pend_q <= 1'b0;
      rd_off_q  <= 8'h00;
    end else if (ce) begin
      wr_pend_q <= addr_take && hwrite;
      rd_pend_q <= addr_take && !hwrite;
      if (addr_take) begin
        wr_off_q <= bus_off(haddr);
        rd_off_q <= bus_off(haddr);
      end
    end
  end

  // wait state lets a read see a write committed just before it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (ce && rd_pend_q) begin
      hrdata_q <= rd_mux(rd_off_q);
    end
  end

  // ****************************************
  // record port and shared write path
  // ****************************************
  // bus write has priority; a clashing record write waits a cycle
  assign rec_off  = path_off({rec_slot, rec_subslot, rec_index});
  assign rec_take = rec_req && !rec_ack_q && !(rec_write && wr_pend_q);
  assign wr_en    = wr_pend_q || (rec_take && rec_write);
  assign wr_off   = wr_pend_q ? wr_off_q : rec_off;
  assign wr_data  = wr_pend_q ? hwdata : rec_wdata;
  assign rec_ack   = rec_ack_q;
  assign rec_err   = rec_err_q;
  assign rec_rdata = rec_rdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_ack_q   <= 1'b0;
      rec_err_q   <= 1'b0;
      rec_rdata_q <= 32'h00000000;
    end else if (ce) begin
      rec_ack_q <= rec_take;
      if (rec_take) begin
        rec_rdata_q <= rec_write ? 32'h00000000 : rd_mux(rec_off);
        rec_err_q   <= (rec_off == OFF_NONE) ||
                       (rec_write && rec_off == OFF_CAL_INST && !page_ok(rec_wdata));
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      no_valve_q <= 1'b0;
      safe_st_q  <= SAFE_CLOSED;
      safe_val_q <= 16'h0000;
      alm_mask_q <= RST_MASK;
      wrn_mask_q <= RST_MASK;
      ip_q       <= RST_IP_ADDR;
      nmask_q    <= RST_NET_MASK;
    end else if (ce && wr_en) begin
      unique case (wr_off)
        OFF_CTRL:     no_valve_q <= wr_data[CTRL_NO_VALVE];
        OFF_SAFE_ST:  safe_st_q  <= fsss_safe_t'(wr_data[1:0]);
        OFF_SAFE_VAL: safe_val_q <= wr_data[15:0];
        OFF_ALM_MASK: alm_mask_q <= wr_data;
        OFF_WRN_MASK: wrn_mask_q <= wr_data;
        OFF_IP_ADDR:  ip_q       <= wr_data;
        OFF_NET_MASK: nmask_q    <= wr_data;
        default:      ;
      endcase
    end
  end

  // set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_q <= 32'h00000000;
    end else if (ce) begin
      if (wr_en && wr_off == OFF_ERROR) begin
        err_q <= (err_q & ~wr_data) | error_events;
      end else begin
        err_q <= err_q | error_events;
      end
    end
  end

  // ****************************************
  // cyclic data and gas page selection
  // ****************************************
  // meter variant has no setpoint output, so it reads as zero
  assign sp_zero = meter_only || (flow_setpoint_value[30:0] == 31'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setpt_q <= 32'h00000000;
      flow_q  <= 32'h00000000;
    end else if (ce) begin
      setpt_q <= meter_only ? 32'h00000000 : flow_setpoint_value;
      flow_q  <= measured_flow_value;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_q      <= RST_CAL_INST;
      bad_page_q <= 1'b0;
    end else if (ce) begin
      if (wr_en && wr_off == OFF_CAL_INST && page_ok(wr_data)) begin
        cal_q <= wr_data[7:0];
      end
      if (wr_en && wr_off == OFF_ALM_STAT && wr_data[ALM_BAD_PAGE]) begin
        bad_page_q <= 1'b0;
      end
      if (cyc_strobe) begin
        if (cyc_page_sel == 8'h00) begin
          bad_page_q <= 1'b0;
        end else if (cyc_page_sel > PAGE_MAX || !page_ok({24'h0, cyc_page_sel})) begin
          bad_page_q <= 1'b1;
        end else if (sp_zero) begin
          cal_q      <= cyc_page_sel;
          bad_page_q <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // safe mode and valve drive
  // ****************************************
  assign safe_mode   = safe_q;
  assign loop_halt   = safe_q;
  assign valve_drive = drive_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      safe_q <= 1'b1;
    end else if (ce) begin
      safe_q <= (|err_q) || (|error_events) || !cyclic_active;
    end
  end

  // normally open valve needs inverted drive for the same position
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_q <= DRIVE_ZERO;
    end else if (ce) begin
      if (!safe_q) begin
        drive_q <= loop_drive;
      end else begin
        unique case (safe_st_q)
          SAFE_CLOSED: drive_q <= no_valve_q ? DRIVE_FULL : DRIVE_ZERO;
          SAFE_OPEN:   drive_q <= no_valve_q ? DRIVE_ZERO : DRIVE_FULL;
          SAFE_HOLD:   drive_q <= drive_q;
          SAFE_VALUE:  drive_q <= no_valve_q ? ~safe_val_q : safe_val_q;
        endcase
      end
    end
  end

  // ****************************************
  // network status indicator
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_cnt_q <= '0;
      flash_q     <= 1'b0;
    end else if (ce) begin
      if (flash_cnt_q == FLASH_CNT_W'(HALF_CYC - 1)) begin
        flash_cnt_q <= '0;
        flash_q     <= !flash_q;
      end else begin
        flash_cnt_q <= flash_cnt_q + FLASH_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_q <= LED_DARK;
    end else if (ce) begin
      if (self_test_busy) begin
        led_q <= LED_TEST;
      end else if (!ip_configured || !name_set) begin
        led_q <= LED_DARK;
      end else if (!cyclic_active) begin
        led_q <= LED_FLASH;
      end else begin
        led_q <= LED_STEADY;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      network_status_indicator_green <= 1'b0;
      network_status_indicator_red   <= 1'b0;
    end else if (ce) begin
      unique case (led_q)
        LED_DARK: begin
          network_status_indicator_green <= 1'b0;
          network_status_indicator_red   <= 1'b0;
        end
        LED_TEST: begin
          network_status_indicator_green <= flash_q;
          network_status_indicator_red   <= !flash_q;
        end
        LED_FLASH: begin
          network_status_indicator_green <= flash_q;
          network_status_indicator_red   <= 1'b0;
        end
        LED_STEADY: begin
          network_status_indicator_green <= 1'b1;
          network_status_indicator_red   <= 1'b0;
        end
      endcase
    end
  end

endmodule

// *** testbench/fsss_props.sv ***
// Purpose: port checker for the safe-state supervisor
// Assumes: one clock domain, ce held high by the bench except for one short stall
// Notes:   bound to fsss_top below the module
module fsss_props #(
  parameter int unsigned HALF_CYC = 8
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        ip_configured,
  input wire logic        name_set,
  input wire logic        self_test_busy,
  input wire logic        cyclic_active,
  input wire logic [31:0] error_events,
  input wire logic [15:0] loop_drive,
  input wire logic        rec_req,
  input wire logic        rec_write,
  input wire logic        rec_ack,
  input wire logic        safe_mode,
  input wire logic        loop_halt,
  input wire logic [15:0] valve_drive,
  input wire logic        network_status_indicator_green,
  input wire logic        network_status_indicator_red
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // helpers
  // ****************
  wire grn = network_status_indicator_green;
  wire red = network_status_indicator_red;
  wire run = ce && !self_test_busy && ip_configured && name_set;
  wire rd_go = ce && hsel && hready && htrans[1] && !hwrite;
  logic        grn_q;
  logic [31:0] still_q;
  // cycles green stood still in self-test; slack covers entry latency
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grn_q <= 1'b0;
      still_q <= '0;
    end else begin
      grn_q <= grn;
      still_q <= (self_test_busy && grn == grn_q) ? still_q + 1 : '0;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************
  // properties
  // ****************
  safe_link_a: assert property (ce && !cyclic_active |=> safe_mode)
    else $error("no link but not safe");
  safe_err_a: assert property (ce && error_events != 0 |=> safe_mode)
    else $error("error event but not safe");
  halt_match_a: assert property (loop_halt == safe_mode)
    else $error("loop halt differs from safe mode");
  run_drive_a: assert property (ce && !safe_mode |=> valve_drive == $past(loop_drive))
    else $error("valve not following loop");
  dark_led_a: assert property (ce && !self_test_busy && !(ip_configured && name_set)
    |-> ##2 !grn && !red)
    else $error("indicator lit while unconfigured");
  flash_led_a: assert property (run && !cyclic_active |-> ##2 !red)
    else $error("red while waiting for link");
  steady_led_a: assert property (run && cyclic_active |-> ##2 grn && !red)
    else $error("not steady green");
  // flops still see reset at the release edge, so attempts start one edge later
  test_led_a: assert property (hresetn && ce && self_test_busy ##1 self_test_busy
    |-> ##1 grn != red)
    else $error("self-test not alternating");
  test_rate_a: assert property (still_q <= HALF_CYC + 3)
    else $error("flash period too long");
  rec_ack_a: assert property (ce && rec_req && !rec_ack && !rec_write |=> rec_ack)
    else $error("record read not served");
  ack_pulse_a: assert property (rec_ack |=> !rec_ack)
    else $error("record ack longer than one cycle");
  read_wait_a: assert property (rd_go |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  cover property (rec_ack && rec_write);
  cover property (safe_mode ##1 !safe_mode);
  cover property (self_test_busy ##1 !self_test_busy);
endmodule

bind fsss_top fsss_props #(.HALF_CYC(HALF_CYC)) u_props (
  .hclk, .hresetn, .ce, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .ip_configured, .name_set, .self_test_busy, .cyclic_active, .error_events,
  .loop_drive, .rec_req, .rec_write, .rec_ack, .safe_mode, .loop_halt, .valve_drive,
  .network_status_indicator_green, .network_status_indicator_red
);

// *** testbench/fsss_plc.sv ***
// Purpose: cyclic controller model at the far side of the supervisor
// Assumes: worked through its tasks by the bench
// Notes:   released record fields show inverted data, never the last value
module fsss_plc
  import fsss_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        rec_ack,
  input  wire logic        rec_err,
  input  wire logic [31:0] rec_rdata,
  output logic             rec_req,
  output logic             rec_write,
  output logic [7:0]       rec_slot,
  output logic [7:0]       rec_subslot,
  output logic [15:0]      rec_index,
  output logic [31:0]      rec_wdata,
  output logic             cyc_strobe,
  output logic [7:0]       cyc_page_sel,
  output logic [31:0]      flow_setpoint_value,
  output logic             cyclic_active,
  output logic             hang
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {rec_req, rec_write, cyc_strobe, cyclic_active, hang} = '0;
    {rec_slot, rec_subslot, rec_index, rec_wdata, cyc_page_sel} = '0;
    flow_setpoint_value = '0;
  end
  task automatic rec(input logic w, input logic [31:0] p, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge hclk);
    rec_req <= 1'b1;
    rec_write <= w;
    {rec_slot, rec_subslot, rec_index} <= p;
    rec_wdata <= d;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (rec_ack !== 1'b1 && n < 64);
    hang <= hang | (rec_ack !== 1'b1);
    q = rec_rdata;
    e = rec_err;
    rec_req <= 1'b0;
    {rec_slot, rec_subslot, rec_index, rec_wdata} <= ~{p, d};
  endtask
  // setpoint and page select travel in the same cyclic frame
  task automatic cyc(input logic [7:0] pg, input logic [31:0] sp);
    @(posedge hclk);
    flow_setpoint_value <= sp;
    cyc_page_sel <= pg;
    cyc_strobe <= 1'b1;
    @(posedge hclk);
    cyc_strobe <= 1'b0;
    cyc_page_sel <= ~pg;
  endtask
  task automatic link(input logic up, input logic cfg);
    logic [31:0] q;
    logic        e;
    if (up && cfg) begin
      rec(1'b1, PATH_ALM_MASK, RST_MASK, q, e);
    end
    @(posedge hclk);
    cyclic_active <= up;
  endtask
endmodule

// *** testbench/fsss_tb_top.sv ***
// Purpose: self-checking bench for the safe-state supervisor
// Assumes: flash half period shortened to 8 cycles
// Notes:   seeded shift register feeds loop, flow and safe values
module fsss_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fsss_pkg::*;
  localparam int unsigned H = 8;
  logic        hclk = 1'b0;
  logic        hresetn, ce, hsel, hwrite, hreadyout, hresp, e, hang;
  logic        ip_configured, name_set, self_test_busy, meter_only, cyclic_active;
  logic        cyc_strobe, rec_req, rec_write, rec_ack, rec_err, safe_mode, loop_halt;
  logic        grn, red;
  logic [1:0]  htrans;
  logic [2:0]  cal_module_count;
  logic [7:0]  cyc_page_sel, rec_slot, rec_subslot;
  logic [15:0] rec_index, loop_drive, valve_drive, x16;
  logic [31:0] haddr, hwdata, hrdata, error_events, flow_setpoint_value;
  logic [31:0] measured_flow_value, rec_wdata, rec_rdata, rnd, q;
  int          mismatches, comparisons, tg, rn, eq;
  always #2 hclk = ~hclk;
  fsss_top #(.HALF_CYC(H)) dut (
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ip_configured, .name_set,
    .self_test_busy, .cyclic_active, .meter_only, .error_events, .cal_module_count,
    .cyc_strobe, .cyc_page_sel, .flow_setpoint_value, .measured_flow_value, .loop_drive,
    .rec_req, .rec_write, .rec_slot, .rec_subslot, .rec_index, .rec_wdata, .rec_ack,
    .rec_err, .rec_rdata, .safe_mode, .loop_halt, .valve_drive,
    .network_status_indicator_green(grn), .network_status_indicator_red(red));
  fsss_plc plc (
    .hclk, .rec_ack, .rec_err, .rec_rdata, .rec_req, .rec_write, .rec_slot,
    .rec_subslot, .rec_index, .rec_wdata, .cyc_strobe, .cyc_page_sel,
    .flow_setpoint_value, .cyclic_active, .hang);
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_drive(input logic [1:0] st, input logic no,
                                            input logic [15:0] sv, input logic [15:0] hd);
    case (st)
      2'h0: return no ? 16'hffff : 16'h0000;
      2'h1: return no ? 16'h0000 : 16'hffff;
      2'h2: return hd;
      default: return no ? ~sv : sv;
    endcase
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge hang) begin
    mismatches++;
    final_report();
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      $display("mismatch at %0t: got %h want %h", $time, g, x);
      mismatches++;
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, 24'h0, a, w};
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 128);
    q = hrdata;
    if (hreadyout !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    ahb(1'b0, a, 32'h0);
    chk(q, x);
    chk(32'(hresp), 32'h0);
  endtask
  task automatic led();
    logic g0;
    {tg, rn, eq} = '0;
    repeat (3) @(posedge hclk);
    g0 = grn;
    repeat (4 * H) begin
      @(posedge hclk);
      tg += int'(grn !== g0);
      rn += int'(red === 1'b1);
      eq += int'(grn === red);
      g0 = grn;
    end
  endtask
  task automatic pg(input logic [31:0] cal, input logic [31:0] alm);
    rd(OFF_CAL_INST, cal);
    rd(OFF_ALM_STAT, alm);
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    {hresetn, hsel, hwrite, ip_configured, name_set, meter_only} = '0;
    {ce, self_test_busy, htrans, cal_module_count} = {1'b1, 1'b1, 2'h0, 3'h3};
    {haddr, hwdata, error_events, measured_flow_value, loop_drive} = '0;
    {mismatches, comparisons} = '0;
    rnd = 32'd99584;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFF_ALM_MASK, 32'h0);
    rd(OFF_WRN_MASK, 32'h0);
    rd(OFF_IP_ADDR, 32'hc0a80164);
    rd(OFF_NET_MASK, 32'hffffff00);
    rd(8'h40, 32'h0);
    pg(32'h1, 32'h0);
    rd(OFF_SAFE_ST, 32'h0);
    chk(32'(safe_mode), 32'h1);
    led();
    chk(32'(tg >= 3 && tg <= 5 && eq == 0), 32'h1);
    {ip_configured, name_set} <= 2'b11;
    plc.link(1'b1, 1'b1);
    led();
    chk(32'(tg >= 3 && tg <= 5 && eq == 0), 32'h1);
    self_test_busy <= 1'b0;
    led();
    chk(32'(tg == 0 && rn == 0 && eq == 0), 32'h1);
    plc.link(1'b0, 1'b0);
    led();
    chk(32'(tg >= 3 && tg <= 5 && rn == 0), 32'h1);
    ip_configured <= 1'b0;
    led();
    chk(32'(rn == 0 && eq == 4 * H), 32'h1);
    ip_configured <= 1'b1;
    plc.link(1'b1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      ahb(1'b1, OFF_CTRL, {31'h0, i[0]});
      ahb(1'b1, OFF_SAFE_VAL, {16'h0, rnd[31:16]});
      plc.rec(1'b1, PATH_SAFE_ST, {30'h0, i[2:1]}, q, e);
      chk(32'(e), 32'h0);
      loop_drive <= rnd[15:0];
      repeat (4) @(posedge hclk);
      chk(32'(valve_drive), {16'h0, rnd[15:0]});
      plc.link(1'b0, 1'b0);
      repeat (2) @(posedge hclk);
      loop_drive <= ~rnd[15:0];
      repeat (4) @(posedge hclk);
      chk({30'h0, loop_halt, safe_mode}, 32'h3);
      x16 = exp_drive(i[2:1], i[0], rnd[31:16], rnd[15:0]);
      chk(32'(valve_drive), {16'h0, x16});
      plc.link(1'b1, i[0]);
    end
    rnd = lfsr(rnd);
    error_events <= 32'h1 << rnd[4:0];
    @(posedge hclk);
    error_events <= 32'h0;
    repeat (4) @(posedge hclk);
    chk(32'(safe_mode), 32'h1);
    plc.rec(1'b0, PATH_ERROR, 32'h0, q, e);
    chk(q, 32'h1 << rnd[4:0]);
    plc.rec(1'b1, PATH_ERROR, q, q, e);
    repeat (4) @(posedge hclk);
    chk(32'(safe_mode), 32'h0);
    ce <= 1'b0;
    plc.link(1'b0, 1'b0);
    repeat (4) @(posedge hclk);
    chk(32'(safe_mode), 32'h0);
    ce <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(32'(safe_mode), 32'h1);
    plc.rec(1'b0, 32'h09010001, 32'h0, q, e);
    chk(32'(e), 32'h1);
    measured_flow_value <= rnd;
    rd(OFF_FLOW, rnd);
    plc.cyc(8'h0, 32'h0);
    pg(32'h1, 32'h0);
    plc.cyc(8'h5, 32'h0);
    pg(32'h1, 32'h1);
    plc.cyc(8'h0, 32'h0);
    pg(32'h1, 32'h0);
    plc.cyc(8'h3, 32'h3f800000);
    pg(32'h1, 32'h0);
    plc.cyc(8'h3, 32'h80000000);
    pg(32'h3, 32'h0);
    rd(OFF_SETPOINT, 32'h80000000);
    plc.cyc(8'h7, 32'h0);
    pg(32'h3, 32'h1);
    meter_only <= 1'b1;
    plc.cyc(8'h2, 32'h3f800000);
    pg(32'h2, 32'h0);
    rd(OFF_SETPOINT, 32'h0);
    plc.rec(1'b1, PATH_CAL_INST, 32'h4, q, e);
    chk(32'(e), 32'h1);
    ahb(1'b1, OFF_CAL_INST, 32'h0);
    rd(OFF_CAL_INST, 32'h2);
    final_report();
  end
endmodule
